/* mrsc_cal.sv */
module mrsc_cal
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire mrsc_pkg::mrsc_cal_action_t action_i,
  input wire logic soft_reset_i,
  input wire logic strap_absent_i,
  // Status
  output logic busy_o,
  output logic current_en_o,
  output logic calibrated_o
);
  import mrsc_pkg::*;

  logic busy, next_busy;
  logic current_en, next_current_en;
  logic calibrated, next_calibrated;
  logic [7:0] cnt, next_cnt;

  // Calibration sequencing
  always_comb
  begin
    next_busy = busy;
    next_current_en = current_en;
    next_calibrated = calibrated;
    next_cnt = cnt;
    if (soft_reset_i)
    begin
      next_busy = 1'b0;
      next_current_en = 1'b0;
      next_calibrated = 1'b0;
    end
    else if (busy)
    begin
      next_cnt = cnt - 8'h01;
      if (cnt == 8'h01)
      begin
        next_busy = 1'b0;
        next_current_en = 1'b0; // [R20]
        next_calibrated = 1'b1;
      end
    end
    else if (start_i && !strap_absent_i) // [R21]
    begin
      unique case (action_i)
        CAL_RESET_ACTION: next_calibrated = 1'b0; // [R22]
        CAL_INIT_ACTION:
        begin
          next_busy = 1'b1;
          next_current_en = 1'b1;
          next_cnt = CAL_INIT_PERIOD_CYC;
        end
        CAL_LONG_ACTION:
        begin
          next_busy = 1'b1;
          next_current_en = 1'b1;
          next_cnt = CAL_LONG_PERIOD_CYC;
        end
        CAL_SHORT_ACTION:
        begin
          next_busy = 1'b1;
          next_current_en = 1'b1;
          next_cnt = CAL_SHORT_PERIOD_CYC;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy <= 1'b0;
      current_en <= 1'b0;
      calibrated <= 1'b0;
      cnt <= 8'h00;
    end
    else
    begin
      busy <= next_busy;
      current_en <= next_current_en;
      calibrated <= next_calibrated;
      cnt <= next_cnt;
    end
  end

  assign busy_o = busy;
  assign current_en_o = current_en;
  assign calibrated_o = calibrated;

endmodule : mrsc_cal

/* mrsc_checker.sv */
module mrsc_checker
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // Link signals
  input wire logic cs_n,
  input wire logic cke,
  input wire logic [mrsc_pkg::CA_W-1:0] ca_r,
  input wire logic [mrsc_pkg::CA_W-1:0] ca_f,
  input wire logic [mrsc_pkg::DQ_W-1:0] dq,
  input wire logic dq_oe_n,
  input wire logic dqs
);
  timeunit 1ns;
  timeprecision 1ps;
  import mrsc_pkg::*;
  logic [7:0] adr;
  logic rd;
  logic wr;
  logic pat;
  logic next_pat;
  logic [7:0] quiet;
  logic [7:0] next_quiet;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SRST_I);
  // Command decode as seen on the link
  assign adr = {ca_f[1:0], ca_r[9:4]};
  assign rd = !cs_n && ca_r[3:0] == CMD_MODE_REG_READ;
  assign wr = !cs_n && ca_r[3:0] == CMD_MODE_REG_WRITE;
  // Marks a running burst as a pattern read
  always_comb
  begin
    next_pat = pat;
    if (rd)
      next_pat = adr == MR_ADDR_CAL_PATTERN_A || adr == MR_ADDR_CAL_PATTERN_B;
  end
  // Counts down a soft reset or init calibration period seen on the link
  always_comb
  begin
    next_quiet = (quiet != 8'h00) ? quiet - 8'h01 : 8'h00;
    if (wr && adr == MR_ADDR_SOFT_RESET)
      next_quiet = SOFT_RESET_PERIOD_CYC;
    if (wr && adr == MR_ADDR_IMPEDANCE_CAL_CTRL && ca_f[9:2] == CAL_CODE_INIT)
      next_quiet = CAL_INIT_PERIOD_CYC;
  end
  always_ff @(posedge MCLK_I)
  begin
    pat <= SRST_I ? 1'b0 : next_pat;
    quiet <= SRST_I ? 8'h00 : next_quiet;
  end
  // Link timing and content
  burst_shape_a: assert property (rd |-> ##4 !dq_oe_n [*4] ##1 dq_oe_n)
    else $error("read burst shape wrong");
  pattern_a_a: assert property (rd && adr == MR_ADDR_CAL_PATTERN_A |-> ##4 dq[0] ##1 !dq[0] ##1 dq[0] ##1 !dq[0])
    else $error("pattern A beats wrong");
  pattern_b_a: assert property (rd && adr == MR_ADDR_CAL_PATTERN_B |-> ##4 !dq[0] ##1 !dq[0] ##1 dq[0] ##1 dq[0])
    else $error("pattern B beats wrong");
  lane_copy_a: assert property (!dq_oe_n && pat |-> dq[7:0] == {8{dq[0]}} && dq[15:8] == {8{dq[0]}})
    else $error("pattern lanes differ");
  strobe_toggle_a: assert property (!dq_oe_n && !$past(dq_oe_n) |-> dqs != $past(dqs))
    else $error("strobe did not toggle");
  read_nop_a: assert property (rd |=> cs_n [*8])
    else $error("command inside read period");
  write_nop_a: assert property (wr |=> cs_n [*5])
    else $error("command inside write period");
  reset_nop_a: assert property (wr && adr == MR_ADDR_SOFT_RESET |=> cs_n [*8])
    else $error("command inside reset period");
  cal_quiet_a: assert property (wr && adr == MR_ADDR_IMPEDANCE_CAL_CTRL |-> (dq_oe_n && cke) [*8])
    else $error("data bus busy during calibration");
  quiet_nop_a: assert property (quiet != 8'h00 |-> cs_n)
    else $error("command inside long quiet period");
  quiet_data_a: assert property (quiet != 8'h00 |-> dq_oe_n)
    else $error("data bus driven inside long quiet period");
endmodule : mrsc_checker

/* mrsc_device.sv */
// Contract
// R1 - Pattern registers return 1010 and 0011
// R2 - Pattern on lanes 0,8 or 0,8,16,24
// R3 - Other lanes of each byte copy lane 0
// R4 - Pattern reads only while device idle
// R5 - Read is a four-beat uninterrupted burst
// R6 - Only no-ops during read command period
// R7 - Write decoded on chip select, bits 3:0 low
// R8 - Address and data taken from both edges
// R9 - Writes to read-only registers change nothing
// R10 - Writes only with all banks precharged
// R11 - Read returns to prior bank state
// R12 - Only no-ops during write; then idle
// R13 - Write to register 63 starts soft reset
// R14 - Soft reset restores defaults, array undefined
// R15 - Only no-ops until reinitialization completes
// R16 - Init calibration once; long, short later
// R17 - Calibration only when idle and precharged
// R18 - No data traffic, clock enable high
// R19 - Shared resistor: no overlapping calibrations
// R20 - Calibration pin current off after calibration
// R21 - Strapped pin ignores calibration commands
// R22 - Calibration reset restores default, no quiet
// R23 - Read decoded on bits 2:0 low, 3 high
// R24 - Calibration action decoded from data byte
module mrsc_device
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // Command and data link
  mrsc_if.mem BUS,
  // Pins and core status
  input wire logic CAL_PIN_STRAP_I,
  input wire logic WIDTH_X16_I,
  input wire logic BANK_ACTIVE_I,
  // Device status
  output mrsc_pkg::mrsc_dev_state_t DEV_STATE_O,
  output logic BANK_ACTIVE_O,
  output logic CAL_BUSY_O,
  output logic CAL_PIN_CURRENT_EN_O,
  output logic DRIVER_CALIBRATED_O,
  output logic ARRAY_UNDEFINED_O
);
  import mrsc_pkg::*;

  mrsc_dev_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [7:0] rd_addr, next_rd_addr;
  logic bank_active, next_bank_active;
  logic array_undefined, next_array_undefined;
  logic [DQ_W-1:0] dq, next_dq;
  logic dq_oe_n, next_dq_oe_n;
  logic dqs, next_dqs;
  logic [7:0] mr [0:MR_COUNT-1];
  logic [7:0] next_mr [0:MR_COUNT-1];
  logic strap_meta, strap_sync;
  logic cal_start;
  mrsc_cal_action_t cal_action;
  logic cal_known;
  logic soft_reset;
  logic is_read, is_write;
  logic [7:0] cmd_addr, cmd_data;
  logic [1:0] beat;
  logic beat_bit;
  logic [7:0] beat_byte;

  // Command decode from the command/address bus
  assign is_write = !BUS.cs_n && BUS.cke && (BUS.ca_r[3:0] == CMD_MODE_REG_WRITE); // [R7]
  assign is_read = !BUS.cs_n && BUS.cke && (BUS.ca_r[3:0] == CMD_MODE_REG_READ); // [R23]
  assign cmd_addr = {BUS.ca_f[1:0], BUS.ca_r[9:4]}; // [R8]
  assign cmd_data = BUS.ca_f[9:2]; // [R8]
  assign soft_reset = (state == DEV_IDLE) && is_write && (cmd_addr == MR_ADDR_SOFT_RESET); // [R13]

  // Calibration action from the control data byte
  always_comb
  begin
    cal_action = CAL_RESET_ACTION;
    cal_known = 1'b1;
    unique case (cmd_data) // [R24]
      CAL_CODE_INIT: cal_action = CAL_INIT_ACTION;
      CAL_CODE_LONG: cal_action = CAL_LONG_ACTION;
      CAL_CODE_SHORT: cal_action = CAL_SHORT_ACTION;
      CAL_CODE_RESET: cal_action = CAL_RESET_ACTION;
      default: cal_known = 1'b0;
    endcase
  end
  assign cal_start = (state == DEV_IDLE) && is_write && (cmd_addr == MR_ADDR_IMPEDANCE_CAL_CTRL) && cal_known;

  // Beat selection for the read burst
  assign beat = 2'(cnt - (READ_LATENCY_CYC - 8'h01));
  always_comb
  begin
    beat_bit = 1'b0;
    beat_byte = 8'h00;
    if (rd_addr == MR_ADDR_CAL_PATTERN_A)
    begin
      beat_bit = CAL_PATTERN_A[beat]; // [R1]
      beat_byte = {8{beat_bit}}; // [R3]
    end
    else if (rd_addr == MR_ADDR_CAL_PATTERN_B)
    begin
      beat_bit = CAL_PATTERN_B[beat]; // [R1]
      beat_byte = {8{beat_bit}}; // [R3]
    end
    else if (beat == 2'h0)
    begin
      beat_byte = mr[rd_addr[5:0]];
    end
  end

  // Device command sequencer
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_rd_addr = rd_addr;
    next_bank_active = BANK_ACTIVE_I;
    next_array_undefined = array_undefined;
    next_dq = {DQ_W{1'b0}};
    next_dq_oe_n = 1'b1;
    next_dqs = 1'b0;
    next_mr = mr;
    unique case (state)
      DEV_IDLE:
      begin
        next_cnt = 8'h00;
        if (is_read)
        begin
          next_state = DEV_READ;
          next_rd_addr = cmd_addr;
        end
        else if (is_write)
        begin
          if (cmd_addr == MR_ADDR_SOFT_RESET)
          begin
            next_state = DEV_RESETTING; // [R13]
            next_array_undefined = 1'b1; // [R14]
            for (int i = 0; i < MR_COUNT; i++)
            begin
              next_mr[i] = MR_DEFAULT; // [R14]
            end
          end
          else
          begin
            next_state = DEV_WRITE;
            if (mrsc_writable(cmd_addr)) // [R9]
            begin
              next_mr[cmd_addr[5:0]] = cmd_data;
            end
          end
        end
      end
      DEV_READ:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt >= READ_LATENCY_CYC - 8'h01)
        begin
          next_dq_oe_n = 1'b0;
          next_dqs = !dqs;
          next_dq[7:0] = beat_byte; // [R2]
          next_dq[15:8] = beat_byte; // [R2]
          if (!WIDTH_X16_I)
          begin
            next_dq[23:16] = beat_byte; // [R2]
            next_dq[31:24] = beat_byte; // [R2]
          end
        end
        // Burst of four runs to the end before the next command
        if (cnt == READ_LATENCY_CYC + BURST_LEN_CYC - 8'h02) // [R5]
        begin
          next_state = DEV_IDLE; // [R11]
        end
      end
      DEV_WRITE:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt == MR_WRITE_PERIOD_CYC - 8'h01)
        begin
          next_state = DEV_IDLE; // [R12]
        end
      end
      DEV_RESETTING:
      begin
        next_cnt = cnt + 8'h01;
        if (cnt == SOFT_RESET_PERIOD_CYC - 8'h01)
        begin
          next_state = DEV_IDLE;
        end
      end
      default:
      begin
        next_state = DEV_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      state <= DEV_IDLE;
      cnt <= 8'h00;
      rd_addr <= 8'h00;
      bank_active <= 1'b0;
      array_undefined <= 1'b0;
      dq <= {DQ_W{1'b0}};
      dq_oe_n <= 1'b1;
      dqs <= 1'b0;
      for (int i = 0; i < MR_COUNT; i++)
      begin
        mr[i] <= MR_DEFAULT;
      end
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      rd_addr <= next_rd_addr;
      bank_active <= next_bank_active;
      array_undefined <= next_array_undefined;
      dq <= next_dq;
      dq_oe_n <= next_dq_oe_n;
      dqs <= next_dqs;
      mr <= next_mr;
    end
  end

  // Strap pin synchroniser
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end
    else
    begin
      strap_meta <= CAL_PIN_STRAP_I;
      strap_sync <= strap_meta;
    end
  end

  // Impedance calibration engine
  mrsc_cal u_cal
  (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .start_i(cal_start),
    .action_i(cal_action),
    .soft_reset_i(soft_reset),
    .strap_absent_i(strap_sync),
    .busy_o(CAL_BUSY_O),
    .current_en_o(CAL_PIN_CURRENT_EN_O),
    .calibrated_o(DRIVER_CALIBRATED_O)
  );

  // Link and status outputs
  assign BUS.dq = dq;
  assign BUS.dq_oe_n = dq_oe_n;
  assign BUS.dqs = dqs;
  assign DEV_STATE_O = state;
  assign BANK_ACTIVE_O = bank_active;
  assign ARRAY_UNDEFINED_O = array_undefined;

endmodule : mrsc_device

/* mrsc_host.sv */
module mrsc_host
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // Command and data link
  mrsc_if.ctrl BUS,
  // User request
  input wire logic REQ_I,
  input wire logic REQ_WRITE_I,
  input wire logic [7:0] REQ_ADDR_I,
  input wire logic [7:0] REQ_DATA_I,
  input wire logic BANK_ACTIVE_I,
  input wire logic SHARED_CAL_BUSY_I,
  // User answer
  output logic READY_O,
  output logic DONE_O,
  output logic REFUSED_O,
  output logic [7:0] RD_BYTE_O,
  output logic [3:0] RD_PATTERN_O,
  output logic CAL_INIT_DONE_O
);
  import mrsc_pkg::*;

  mrsc_host_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [1:0] hbeat, next_hbeat;
  logic cs_n, next_cs_n;
  logic [CA_W-1:0] ca_r, next_ca_r, ca_f, next_ca_f;
  logic ready, next_ready, done, next_done, refused, next_refused;
  logic [7:0] rd_byte, next_rd_byte;
  logic [3:0] rd_pattern, next_rd_pattern;
  logic init_done, next_init_done, pend_init, next_pend_init;
  logic is_cal, is_pat, refuse;
  logic [7:0] wait_cyc;

  // Request classification and refusal
  assign is_cal = REQ_WRITE_I && (REQ_ADDR_I == MR_ADDR_IMPEDANCE_CAL_CTRL);
  assign is_pat = !REQ_WRITE_I && ((REQ_ADDR_I == MR_ADDR_CAL_PATTERN_A) || (REQ_ADDR_I == MR_ADDR_CAL_PATTERN_B));
  always_comb
  begin
    refuse = 1'b0;
    wait_cyc = REQ_WRITE_I ? HOST_WRITE_WAIT : HOST_READ_WAIT;
    if (REQ_WRITE_I && BANK_ACTIVE_I)
      refuse = 1'b1; // [R10] [R17]
    if (is_pat && BANK_ACTIVE_I)
      refuse = 1'b1; // [R4]
    if (REQ_WRITE_I && (REQ_ADDR_I == MR_ADDR_SOFT_RESET))
      wait_cyc = 8'(SOFT_RESET_PERIOD_CYC + HOST_MARGIN); // [R15]
    if (is_cal)
    begin
      if (REQ_DATA_I == CAL_CODE_INIT)
        wait_cyc = 8'(CAL_INIT_PERIOD_CYC + HOST_MARGIN); // [R18]
      if (REQ_DATA_I == CAL_CODE_LONG)
        wait_cyc = 8'(CAL_LONG_PERIOD_CYC + HOST_MARGIN); // [R18]
      if (REQ_DATA_I == CAL_CODE_SHORT)
        wait_cyc = 8'(CAL_SHORT_PERIOD_CYC + HOST_MARGIN); // [R18]
      if (((REQ_DATA_I == CAL_CODE_LONG) || (REQ_DATA_I == CAL_CODE_SHORT)) && !init_done)
        refuse = 1'b1; // [R16]
      if ((REQ_DATA_I != CAL_CODE_RESET) && SHARED_CAL_BUSY_I)
        refuse = 1'b1; // [R19]
    end
  end

  // Host command sequencer
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_hbeat = hbeat;
    next_cs_n = 1'b1;
    next_ca_r = {CA_W{1'b0}};
    next_ca_f = {CA_W{1'b0}};
    next_ready = 1'b0;
    next_done = 1'b0;
    next_refused = 1'b0;
    next_rd_byte = rd_byte;
    next_rd_pattern = rd_pattern;
    next_init_done = init_done;
    next_pend_init = pend_init;
    unique case (state)
      HOST_IDLE:
      begin
        next_ready = 1'b1;
        if (REQ_I && ready && refuse)
        begin
          next_refused = 1'b1;
        end
        else if (REQ_I && ready)
        begin
          next_ready = 1'b0;
          next_state = HOST_WAIT;
          next_cnt = wait_cyc;
          next_hbeat = 2'h0;
          next_cs_n = 1'b0;
          next_ca_r = {REQ_ADDR_I[5:0], REQ_WRITE_I ? CMD_MODE_REG_WRITE : CMD_MODE_REG_READ};
          next_ca_f = {REQ_DATA_I, REQ_ADDR_I[7:6]};
          next_pend_init = is_cal && (REQ_DATA_I == CAL_CODE_INIT);
          if (REQ_WRITE_I && (REQ_ADDR_I == MR_ADDR_SOFT_RESET))
            next_init_done = 1'b0;
        end
      end
      HOST_WAIT:
      begin
        // No-ops until the period and any burst are over
        next_cnt = cnt - 8'h01; // [R6] [R12] [R15] [R18]
        if (!BUS.dq_oe_n)
        begin
          next_hbeat = hbeat + 2'h1;
          next_rd_pattern[hbeat] = BUS.dq[0];
          if (hbeat == 2'h0)
            next_rd_byte = BUS.dq[7:0];
        end
        if (cnt == 8'h01)
        begin
          next_state = HOST_DONE;
          next_done = 1'b1;
          if (pend_init)
            next_init_done = 1'b1;
        end
      end
      HOST_DONE:
      begin
        next_state = HOST_IDLE;
        next_ready = 1'b1;
      end
      default:
      begin
        next_state = HOST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      state <= HOST_IDLE;
      cnt <= 8'h00;
      hbeat <= 2'h0;
      cs_n <= 1'b1;
      ca_r <= {CA_W{1'b0}};
      ca_f <= {CA_W{1'b0}};
      ready <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      rd_byte <= 8'h00;
      rd_pattern <= 4'h0;
      init_done <= 1'b0;
      pend_init <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      hbeat <= next_hbeat;
      cs_n <= next_cs_n;
      ca_r <= next_ca_r;
      ca_f <= next_ca_f;
      ready <= next_ready;
      done <= next_done;
      refused <= next_refused;
      rd_byte <= next_rd_byte;
      rd_pattern <= next_rd_pattern;
      init_done <= next_init_done;
      pend_init <= next_pend_init;
    end
  end

  // Link and user outputs
  assign BUS.cs_n = cs_n;
  assign BUS.cke = 1'b1;
  assign BUS.ca_r = ca_r;
  assign BUS.ca_f = ca_f;
  assign READY_O = ready;
  assign DONE_O = done;
  assign REFUSED_O = refused;
  assign RD_BYTE_O = rd_byte;
  assign RD_PATTERN_O = rd_pattern;
  assign CAL_INIT_DONE_O = init_done;

endmodule : mrsc_host

/* mrsc_if.sv */
interface mrsc_if;
  // Command/address, one beat per edge pair
  logic cs_n;
  logic cke;
  logic [mrsc_pkg::CA_W-1:0] ca_r;
  logic [mrsc_pkg::CA_W-1:0] ca_f;
  // Data lanes and strobe
  logic [mrsc_pkg::DQ_W-1:0] dq;
  logic dq_oe_n;
  logic dqs;

  modport ctrl (output cs_n, cke, ca_r, ca_f, input dq, dq_oe_n, dqs);
  modport mem (input cs_n, cke, ca_r, ca_f, output dq, dq_oe_n, dqs);
endinterface : mrsc_if

/* mrsc_pkg.sv */
package mrsc_pkg;

  // Clock and bus widths
  localparam int CLK_PERIOD_NS = 50;
  localparam int DQ_W = 32;
  localparam int CA_W = 10;
  localparam int MR_COUNT = 64;

  // Mode register addresses
  localparam logic [7:0] MR_ADDR_CAL_PATTERN_A = 8'h20;
  localparam logic [7:0] MR_ADDR_CAL_PATTERN_B = 8'h28;
  localparam logic [7:0] MR_ADDR_SOFT_RESET = 8'h3F;
  localparam logic [7:0] MR_ADDR_IMPEDANCE_CAL_CTRL = 8'h0A;

  // Calibration patterns, bit n is beat n
  localparam logic [3:0] CAL_PATTERN_A = 4'h5;
  localparam logic [3:0] CAL_PATTERN_B = 4'hC;

  // Rising-edge command codes on command/address bits 3:0
  localparam logic [3:0] CMD_MODE_REG_WRITE = 4'h0;
  localparam logic [3:0] CMD_MODE_REG_READ = 4'h8;

  // Data byte codes of the calibration control register
  localparam logic [7:0] CAL_CODE_INIT = 8'hFF;
  localparam logic [7:0] CAL_CODE_LONG = 8'hAB;
  localparam logic [7:0] CAL_CODE_SHORT = 8'h56;
  localparam logic [7:0] CAL_CODE_RESET = 8'hC3;

  // Reset value of every mode register
  localparam logic [7:0] MR_DEFAULT = 8'h00;

  // Cycle figures given in clocks
  localparam logic [7:0] READ_LATENCY_CYC = 8'h03;
  localparam logic [7:0] BURST_LEN_CYC = 8'h04;
  localparam logic [7:0] MR_READ_PERIOD_CYC = 8'h02;
  localparam logic [7:0] MR_WRITE_PERIOD_CYC = 8'h05;

  // Times in ns and their least cycle counts
  localparam int CAL_INIT_PERIOD_NS = 1000;
  localparam int CAL_LONG_PERIOD_NS = 400;
  localparam int CAL_SHORT_PERIOD_NS = 100;
  localparam int CAL_RESET_PERIOD_NS = 50;
  localparam int SOFT_RESET_PERIOD_NS = 2000;
  localparam logic [7:0] CAL_INIT_PERIOD_CYC = 8'((CAL_INIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CAL_LONG_PERIOD_CYC = 8'((CAL_LONG_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CAL_SHORT_PERIOD_CYC = 8'((CAL_SHORT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CAL_RESET_PERIOD_CYC = 8'((CAL_RESET_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SOFT_RESET_PERIOD_CYC = 8'((SOFT_RESET_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Host wait spans after a command leaves the host
  localparam logic [7:0] HOST_READ_WAIT = 8'(2 + READ_LATENCY_CYC + BURST_LEN_CYC);
  localparam logic [7:0] HOST_WRITE_WAIT = 8'(1 + MR_WRITE_PERIOD_CYC);
  localparam logic [7:0] HOST_MARGIN = 8'h02;

  // Calibration actions
  typedef enum logic [1:0]
  {
    CAL_INIT_ACTION = 2'b00,
    CAL_LONG_ACTION = 2'b01,
    CAL_SHORT_ACTION = 2'b11,
    CAL_RESET_ACTION = 2'b10
  } mrsc_cal_action_t;

  // Device states
  typedef enum logic [2:0]
  {
    DEV_IDLE = 3'b000,
    DEV_READ = 3'b001,
    DEV_WRITE = 3'b011,
    DEV_RESETTING = 3'b010
  } mrsc_dev_state_t;

  // Host states
  typedef enum logic [1:0]
  {
    HOST_IDLE = 2'b00,
    HOST_WAIT = 2'b01,
    HOST_DONE = 2'b11
  } mrsc_host_state_t;

  // Registers that software may write
  function automatic logic mrsc_writable(input logic [7:0] addr);
    return (addr == 8'h01) || (addr == 8'h02) || (addr == 8'h03) || (addr == 8'h10) || (addr == 8'h11);
  endfunction : mrsc_writable

endpackage : mrsc_pkg

/* mrsc_tb.sv */
`define CHK(act, exp) \
  begin \
    n_compared++; \
    if ((act) !== (exp)) \
    begin \
      bad_count++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (act), (exp)); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mrsc_pkg::*;
  logic mclk, srst, req, rw, bank, shb, strap, x16, r;
  logic [7:0] ra, rdat, rb;
  logic rdy, dn, rf, cid, bko, cb, ce, cal, au, sb, sr;
  logic [3:0] rp;
  logic [DQ_W-1:0] ldq;
  mrsc_dev_state_t ds;
  int bad_count, n_compared;
  mrsc_if bus ();
  mrsc_host mrsc_host_inst (.MCLK_I(mclk), .SRST_I(srst), .BUS(bus.ctrl), .REQ_I(req), .REQ_WRITE_I(rw),
    .REQ_ADDR_I(ra), .REQ_DATA_I(rdat), .BANK_ACTIVE_I(bank), .SHARED_CAL_BUSY_I(shb), .READY_O(rdy),
    .DONE_O(dn), .REFUSED_O(rf), .RD_BYTE_O(rb), .RD_PATTERN_O(rp), .CAL_INIT_DONE_O(cid));
  mrsc_device mrsc_device_inst (.MCLK_I(mclk), .SRST_I(srst), .BUS(bus.mem), .CAL_PIN_STRAP_I(strap),
    .WIDTH_X16_I(x16), .BANK_ACTIVE_I(bank), .DEV_STATE_O(ds), .BANK_ACTIVE_O(bko), .CAL_BUSY_O(cb),
    .CAL_PIN_CURRENT_EN_O(ce), .DRIVER_CALIBRATED_O(cal), .ARRAY_UNDEFINED_O(au));
  mrsc_checker mrsc_checker_inst (.MCLK_I(mclk), .SRST_I(srst), .cs_n(bus.cs_n), .cke(bus.cke), .ca_r(bus.ca_r),
    .ca_f(bus.ca_f), .dq(bus.dq), .dq_oe_n(bus.dq_oe_n), .dqs(bus.dqs));
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end
  // Link and status watcher
  always @(negedge mclk)
  begin
    if (bus.dq_oe_n === 1'b0)
      ldq = bus.dq;
    if (cb === 1'b1 && ce === 1'b1)
      sb = 1'b1;
    if (ds === DEV_RESETTING)
      sr = 1'b1;
  end
  // One user request; o is 1 if refused, 0 if done
  task req_op(input logic w, input logic [7:0] a, input logic [7:0] d, output logic o);
    int i;
    for (i = 0; i < 100 && rdy !== 1'b1; i++)
      @(negedge mclk);
    req = 1'b1;
    rw = w;
    ra = a;
    rdat = d;
    @(negedge mclk);
    req = 1'b0;
    for (i = 0; i < 100 && dn !== 1'b1 && rf !== 1'b1; i++)
      @(negedge mclk);
    o = dn === 1'b1 ? 1'b0 : (rf === 1'b1 ? 1'b1 : 1'bx);
    if (o === 1'bx)
      bad_count++;
    @(negedge mclk);
  endtask : req_op
  // Pattern reads in both widths
  task t_pattern;
    x16 = 1'b0;
    req_op(1'b0, MR_ADDR_CAL_PATTERN_A, 8'h00, r);
    `CHK(rp, CAL_PATTERN_A)
    `CHK(rb, 8'hFF)
    req_op(1'b0, MR_ADDR_CAL_PATTERN_B, 8'h00, r);
    `CHK(rp, CAL_PATTERN_B)
    `CHK(ldq, 32'hFFFFFFFF)
    x16 = 1'b1;
    req_op(1'b0, MR_ADDR_CAL_PATTERN_B, 8'h00, r);
    `CHK(ldq, 32'h0000FFFF)
    `CHK(r, 1'b0)
    $display("test pattern done");
  endtask : t_pattern
  // Writes to writable, aliasing and read-only places
  task t_write;
    req_op(1'b1, 8'h01, 8'h5A, r);
    `CHK(r, 1'b0)
    `CHK(ds, DEV_IDLE)
    req_op(1'b1, 8'h81, 8'h77, r);
    req_op(1'b1, 8'h11, 8'hC3, r);
    req_op(1'b1, 8'h00, 8'hA5, r);
    req_op(1'b0, 8'h01, 8'h00, r);
    `CHK(rb, 8'h5A)
    req_op(1'b0, 8'h11, 8'h00, r);
    `CHK(rb, 8'hC3)
    req_op(1'b0, 8'h00, 8'h00, r);
    `CHK(rb, MR_DEFAULT)
    $display("test write done");
  endtask : t_write
  // Requests with a bank open
  task t_bank;
    bank = 1'b1;
    req_op(1'b1, 8'h02, 8'h33, r);
    `CHK(r, 1'b1)
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_INIT, r);
    `CHK(r, 1'b1)
    req_op(1'b0, MR_ADDR_CAL_PATTERN_A, 8'h00, r);
    `CHK(r, 1'b1)
    req_op(1'b0, 8'h01, 8'h00, r);
    `CHK(rb, 8'h5A)
    `CHK(bko, 1'b1)
    `CHK(ds, DEV_IDLE)
    bank = 1'b0;
    req_op(1'b0, 8'h02, 8'h00, r);
    `CHK(rb, MR_DEFAULT)
    $display("test bank done");
  endtask : t_bank
  // Calibration codes, refusals and strapped pin
  task t_cal;
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_LONG, r);
    `CHK(r, 1'b1)
    shb = 1'b1;
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_INIT, r);
    `CHK(r, 1'b1)
    shb = 1'b0;
    sb = 1'b0;
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_INIT, r);
    `CHK({sb, cal, cid}, 3'b111)
    `CHK(ce, 1'b0)
    sb = 1'b0;
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_LONG, r);
    `CHK({r, sb, cal}, 3'b011)
    sb = 1'b0;
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_SHORT, r);
    `CHK({r, sb, cal}, 3'b011)
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_RESET, r);
    `CHK(cal, 1'b0)
    strap = 1'b1;
    repeat (4) @(negedge mclk);
    sb = 1'b0;
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_INIT, r);
    `CHK({sb, cal}, 2'b00)
    strap = 1'b0;
    repeat (4) @(negedge mclk);
    $display("test cal done");
  endtask : t_cal
  // Soft reset restores defaults
  task t_soft_reset;
    req_op(1'b1, 8'h02, 8'h44, r);
    sr = 1'b0;
    req_op(1'b1, MR_ADDR_SOFT_RESET, 8'h00, r);
    `CHK({sr, au}, 2'b11)
    `CHK(ds, DEV_IDLE)
    req_op(1'b0, 8'h02, 8'h00, r);
    `CHK(rb, MR_DEFAULT)
    req_op(1'b1, MR_ADDR_IMPEDANCE_CAL_CTRL, CAL_CODE_LONG, r);
    `CHK(r, 1'b1)
    $display("test soft reset done");
  endtask : t_soft_reset
  // Verdict and end of run
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Main sequence
  initial
  begin
    {srst, req, rw, bank, shb, strap, x16, sb, sr} = 9'h100;
    ra = 8'h00;
    rdat = 8'h00;
    ldq = '0;
    bad_count = 0;
    n_compared = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    t_pattern;
    t_write;
    t_bank;
    t_cal;
    t_soft_reset;
    end_sim;
  end
  // Watchdog
  initial
  begin
    #(5000 * CLK_PERIOD_NS);
    bad_count++;
    end_sim;
  end
endmodule : testbench
